// ===== common/csc_pkg.sv
package csc_pkg;
  // system clock rate and the start-up intervals in their own units
  localparam int SYS_CLK_KHZ = 10000;
  localparam int XTAL_STARTUP_US = 1000;
  localparam int PLL_SETTLE_US = 500;
  // least times, rounded up to whole system clock cycles
  localparam int XTAL_STARTUP_CYC = (XTAL_STARTUP_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int TMR_W = 16;

  // serial slave address: upper six bits fixed, value is arbitrary
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h2a;
  // configuration register indexes
  localparam logic [7:0] REG_SS100 = 8'h00;
  localparam logic [7:0] REG_HS = 8'h01;
  // field positions inside the data bytes
  localparam int SS100_EN_BIT = 0;
  localparam int HS_FREQ_LSB = 0;
  localparam int HS_SS_EN_BIT = 4;
  localparam int HS_DEPTH_BIT = 5;
  // high-speed frequency code: 200 MHz plus 20 MHz per step, 400 MHz at most
  localparam logic [3:0] HS_FREQ_MAX = 4'ha;
  localparam logic [3:0] HS_FREQ_RST = 4'h5;
  // spread depths in tenths of a percent
  localparam int SS100_DOWN_PERMIL = 5;
  localparam int HS_DEPTH_LO_PERMIL = 10;
  localparam int HS_DEPTH_HI_PERMIL = 15;

  // synthesis configuration handed to the analog side
  typedef struct packed {
    logic ss100_en;
    logic [3:0] hs_freq;
    logic hs_ss_en;
    logic hs_ss_depth;
  } csc_cfg_t;
  localparam csc_cfg_t CFG_RST = '{ss100_en: 1'b1, hs_freq: HS_FREQ_RST, hs_ss_en: 1'b1, hs_ss_depth: 1'b0};

  // power and output control
  typedef struct packed {
    logic xtal_en;
    logic pll100_en;
    logic pllhs_en;
    logic ref_oe;
    logic d100_oe;
    logic dhs_oe;
    logic valid;
  } csc_pwr_t;
  localparam csc_pwr_t PWR_OFF = '0;

  // pin synchroniser reset levels: enable idles high, supply and crystal count as bad until seen good
  localparam logic [3:0] PIN_SYNC_RST = 4'h9;
  localparam logic [2:0] LINK_SYNC_RST = 3'h7;

  // start-up sequencer states
  typedef enum logic [2:0] {
    SU_OFF = 3'h0,
    SU_WAIT = 3'h1,
    SU_XTAL = 3'h3,
    SU_PLL = 3'h2,
    SU_READY = 3'h6
  } csc_su_t;

  // serial slave states
  typedef enum logic [1:0] {
    SL_IDLE = 2'h0,
    SL_ADDR = 2'h1,
    SL_BYTE = 2'h3,
    SL_ACK = 2'h2
  } csc_sl_t;
endpackage

// ===== design/csc_sync3.sv
`timescale 1ns/1ns
module csc_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous level in, filtered level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] f1;  // first stage, read only by f2
    logic [WIDTH-1:0] f2;
    logic [WIDTH-1:0] f3;
    logic [WIDTH-1:0] q;   // accepted level
  } csc_sync_st_t;

  csc_sync_st_t r;
  csc_sync_st_t next_r;

  // shift chain; accept a bit once stages two and three agree
  always_comb
  begin
    next_r = r;
    next_r.f1 = d;
    next_r.f2 = r.f1;
    next_r.f3 = r.f2;
    next_r.q = (r.f3 & ~(r.f2 ^ r.f3)) | (r.q & (r.f2 ^ r.f3));
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{f1: RST_VAL, f2: RST_VAL, f3: RST_VAL, q: RST_VAL};
    else
      r <= next_r;
  end

  assign q = r.q;
endmodule

// ===== design/csc_startup.sv
`timescale 1ns/1ns
module csc_startup #(
  parameter int XTAL_CYC = csc_pkg::XTAL_STARTUP_CYC,
  parameter int PLL_CYC = csc_pkg::PLL_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // filtered pin levels
  input wire logic en,
  input wire logic supply_ok,
  input wire logic xtal_ok,
  // registered power and output control
  output csc_pkg::csc_pwr_t pwr
);
  typedef struct packed {
    csc_pkg::csc_su_t st;                 // sequencer state
    logic [csc_pkg::TMR_W-1:0] tmr;       // interval counter
    csc_pkg::csc_pwr_t pwr;               // control outputs
  } csc_su_st_t;

  csc_su_st_t r;
  csc_su_st_t next_r;

  // sequencer: oscillator, crystal wait, pll settle, ready
  always_comb
  begin
    next_r = r;
    case (r.st)
      // powered down; enable starts the oscillator
      csc_pkg::SU_OFF:
        if (en)
          next_r.st = csc_pkg::SU_WAIT;
      // plls held off until supply and crystal are good
      csc_pkg::SU_WAIT:
        if (supply_ok && xtal_ok)
        begin
          next_r.st = csc_pkg::SU_XTAL;
          next_r.tmr = '0;
        end
      // crystal start-up interval
      csc_pkg::SU_XTAL:
        if (r.tmr == csc_pkg::TMR_W'(XTAL_CYC - 1))
        begin
          next_r.st = csc_pkg::SU_PLL;
          next_r.tmr = '0;
        end
        else
          next_r.tmr = r.tmr + 1'b1;
      // pll settling interval
      csc_pkg::SU_PLL:
        if (r.tmr == csc_pkg::TMR_W'(PLL_CYC - 1))
          next_r.st = csc_pkg::SU_READY;
        else
          next_r.tmr = r.tmr + 1'b1;
      // outputs running
      csc_pkg::SU_READY:
        next_r.st = csc_pkg::SU_READY;
      default:
        next_r.st = csc_pkg::SU_OFF;
    endcase
    // loss of supply or crystal drops back to waiting
    if (r.st != csc_pkg::SU_OFF && !(supply_ok && xtal_ok))
      next_r.st = csc_pkg::SU_WAIT;
    // enable low beats everything else
    if (!en)
      next_r.st = csc_pkg::SU_OFF;
    // controls follow the next state
    next_r.pwr.xtal_en = (next_r.st != csc_pkg::SU_OFF);
    next_r.pwr.pll100_en = (next_r.st == csc_pkg::SU_PLL) || (next_r.st == csc_pkg::SU_READY);
    next_r.pwr.pllhs_en = next_r.pwr.pll100_en;
    // all three drivers switch together, only once ready
    next_r.pwr.ref_oe = (next_r.st == csc_pkg::SU_READY);
    next_r.pwr.d100_oe = next_r.pwr.ref_oe;
    next_r.pwr.dhs_oe = next_r.pwr.ref_oe;
    next_r.pwr.valid = next_r.pwr.ref_oe;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{st: csc_pkg::SU_OFF, tmr: '0, pwr: csc_pkg::PWR_OFF};
    else
      r <= next_r;
  end

  assign pwr = r.pwr;
endmodule

// ===== design/csc_top.sv
// How it works
// - 100 MHz down spread on by default
// - serial write switches 100 MHz spread
// - high-speed frequency 200-400 MHz, 20 MHz steps
// - high-speed center spread 1.0/1.5, can disable
// - plls off until supply and crystal good
// - valid after crystal then pll intervals
// - enable high runs outputs per serial settings
// - enable low: drivers off, plls, oscillator off
// - enable low overrides all serial settings
// - one enable for all outputs, idles high
// - address bit zero from strap, idles high
// - reference output buffers crystal, bypasses plls
`timescale 1ns/1ns
module csc_top #(
  parameter int XTAL_CYC = csc_pkg::XTAL_STARTUP_CYC,
  parameter int PLL_CYC = csc_pkg::PLL_SETTLE_CYC
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link: sampling clock and the two bus lines
  input wire logic clk_link,
  input wire logic serial_clock,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_n,
  // device pins
  input wire logic output_enable_pin,
  input wire logic address_strap_pin,
  input wire logic supply_ok,
  input wire logic xtal_stable,
  // synthesis and power control
  output csc_pkg::csc_cfg_t synth_cfg,
  output csc_pkg::csc_pwr_t pwr_ctl
);
  // link domain state
  typedef struct packed {
    csc_pkg::csc_sl_t st;         // slave state
    logic [3:0] bits;             // bits shifted in this byte
    logic [7:0] shreg;            // receive shift register
    logic [7:0] ptr;              // register index
    logic first;                  // next byte is the index
    logic ok;                     // transaction addressed and acked so far
    logic wrote;                  // at least one data byte taken
    logic scl_q;                  // previous filtered clock
    logic sda_q;                  // previous filtered data
    logic sda_o;                  // open-drain level, always low
    logic sda_oe_n;               // low while pulling the line
    csc_pkg::csc_cfg_t stage;     // settings of the open write
    csc_pkg::csc_cfg_t commit;    // last complete write
    logic tgl;                    // flips on each commit
  } csc_link_st_t;

  // system domain state
  typedef struct packed {
    logic t1;                     // toggle sync stage one
    logic t2;
    logic t3;
    csc_pkg::csc_cfg_t cfg;       // settings in force
  } csc_sys_st_t;

  // reset release flops per domain
  logic rs1;
  logic rs2;
  logic lrs1;
  logic lrs2;
  // filtered pins
  logic [3:0] pins;
  logic [2:0] lpins;
  logic scl;
  logic sda;
  logic a0;
  logic [6:0] my_addr;
  // state registers
  csc_link_st_t l;
  csc_link_st_t next_l;
  csc_sys_st_t s;
  csc_sys_st_t next_s;
  // bus events
  logic ev_start;
  logic ev_stop;
  logic ev_rise;
  logic ev_fall;

  // system reset: asserted at once, released after two edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
    end
    else
    begin
      rs1 <= 1'b1;
      rs2 <= rs1;
    end
  end

  // link reset, released the same way on the link clock
  always_ff @(posedge clk_link or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lrs1 <= 1'b0;
      lrs2 <= 1'b0;
    end
    else
    begin
      lrs1 <= 1'b1;
      lrs2 <= lrs1;
    end
  end

  // enable, supply and crystal pins into the system domain; enable idles high, supply and crystal low
  csc_sync3 #(
    .WIDTH(4),
    .RST_VAL(csc_pkg::PIN_SYNC_RST)
  ) u_pin_sync (
    .clk(clk_sys),
    .rst_n(rs2),
    .d({output_enable_pin, supply_ok, xtal_stable, 1'b1}),
    .q(pins)
  );

  // bus lines and address strap into the link domain; idle high
  csc_sync3 #(
    .WIDTH(3),
    .RST_VAL(csc_pkg::LINK_SYNC_RST)
  ) u_link_sync (
    .clk(clk_link),
    .rst_n(lrs2),
    .d({serial_clock, serial_data_line_i, address_strap_pin}),
    .q(lpins)
  );

  // power sequencing; enable pin gates all three outputs together
  csc_startup #(
    .XTAL_CYC(XTAL_CYC),
    .PLL_CYC(PLL_CYC)
  ) u_startup (
    .clk_sys(clk_sys),
    .rst_n(rs2),
    .en(pins[3]),
    .supply_ok(pins[2]),
    .xtal_ok(pins[1]),
    .pwr(pwr_ctl)
  );

  // filtered lines and our own address
  assign scl = lpins[2];
  assign sda = lpins[1];
  assign a0 = lpins[0];
  assign my_addr = {csc_pkg::SLAVE_ADDR_HI, a0};

  // bus conditions seen on the filtered lines
  assign ev_start = l.scl_q && scl && l.sda_q && !sda;
  assign ev_stop = l.scl_q && scl && !l.sda_q && sda;
  assign ev_rise = !l.scl_q && scl;
  assign ev_fall = l.scl_q && !scl;

  // serial slave: address, index byte, then data bytes with auto-increment
  always_comb
  begin
    next_l = l;
    next_l.scl_q = scl;
    next_l.sda_q = sda;
    if (ev_start)
    begin
      // start or repeated start opens a fresh write from the live settings
      next_l.st = csc_pkg::SL_ADDR;
      next_l.bits = '0;
      next_l.first = 1'b1;
      next_l.ok = 1'b0;
      next_l.wrote = 1'b0;
      next_l.sda_oe_n = 1'b1;
      next_l.stage = l.commit;
    end
    else if (ev_stop)
    begin
      // commit only a write that ended on a byte boundary with all acked;
      // the clock rise ahead of the stop has already counted one bit
      if (l.ok && l.wrote && l.st == csc_pkg::SL_BYTE && l.bits == 4'h1)
      begin
        next_l.commit = l.stage;
        next_l.tgl = !l.tgl;
      end
      next_l.st = csc_pkg::SL_IDLE;
      next_l.ok = 1'b0;
      next_l.sda_oe_n = 1'b1;
    end
    else if (ev_rise)
    begin
      // sample a data bit while the clock is high
      if (l.st == csc_pkg::SL_ADDR || l.st == csc_pkg::SL_BYTE)
      begin
        next_l.shreg = {l.shreg[6:0], sda};
        next_l.bits = l.bits + 4'h1;
      end
    end
    else if (ev_fall)
    begin
      case (l.st)
        // address byte: acknowledge writes to our address only
        csc_pkg::SL_ADDR:
          if (l.bits == 4'h8)
          begin
            if (l.shreg[7:1] == my_addr && !l.shreg[0])
            begin
              next_l.ok = 1'b1;
              next_l.sda_oe_n = 1'b0;
              next_l.st = csc_pkg::SL_ACK;
            end
            else
              next_l.st = csc_pkg::SL_IDLE;
          end
        // index or data byte
        csc_pkg::SL_BYTE:
          if (l.bits == 4'h8)
          begin
            next_l.sda_oe_n = 1'b0;
            next_l.st = csc_pkg::SL_ACK;
            if (l.first)
            begin
              // index byte
              next_l.ptr = l.shreg;
              next_l.first = 1'b0;
            end
            else if (l.ptr == csc_pkg::REG_SS100)
            begin
              // 100 MHz spread switch
              next_l.stage.ss100_en = l.shreg[csc_pkg::SS100_EN_BIT];
              next_l.wrote = 1'b1;
              next_l.ptr = l.ptr + 8'h01;
            end
            else if (l.ptr == csc_pkg::REG_HS && l.shreg[csc_pkg::HS_FREQ_LSB +: 4] <= csc_pkg::HS_FREQ_MAX)
            begin
              // high-speed frequency step and center spread
              next_l.stage.hs_freq = l.shreg[csc_pkg::HS_FREQ_LSB +: 4];
              next_l.stage.hs_ss_en = l.shreg[csc_pkg::HS_SS_EN_BIT];
              next_l.stage.hs_ss_depth = l.shreg[csc_pkg::HS_DEPTH_BIT];
              next_l.wrote = 1'b1;
              next_l.ptr = l.ptr + 8'h01;
            end
            else
            begin
              // unknown index or frequency out of range: refuse and drop the write
              next_l.sda_oe_n = 1'b1;
              next_l.ok = 1'b0;
              next_l.st = csc_pkg::SL_IDLE;
            end
          end
        // end of the acknowledge bit: release the line
        csc_pkg::SL_ACK:
        begin
          next_l.sda_oe_n = 1'b1;
          next_l.bits = '0;
          next_l.st = csc_pkg::SL_BYTE;
        end
        // idle: wait for a start
        csc_pkg::SL_IDLE:
          next_l.st = csc_pkg::SL_IDLE;
        default:
          next_l.st = csc_pkg::SL_IDLE;
      endcase
    end
  end

  // link state register; defaults give 0.5 percent down spread on 100 MHz
  always_ff @(posedge clk_link or negedge lrs2)
  begin
    if (!lrs2)
      l <= '{st: csc_pkg::SL_IDLE, bits: '0, shreg: '0, ptr: '0, first: 1'b0, ok: 1'b0,
             wrote: 1'b0, scl_q: 1'b1, sda_q: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1,
             stage: csc_pkg::CFG_RST, commit: csc_pkg::CFG_RST, tgl: 1'b0};
    else
      l <= next_l;
  end

  // commit word stays still for a whole transaction, so the toggle edge
  // marks the moment it may be taken into the system domain
  always_comb
  begin
    next_s = s;
    next_s.t1 = l.tgl;
    next_s.t2 = s.t1;
    next_s.t3 = s.t2;
    if (s.t2 != s.t3)
      next_s.cfg = l.commit;
  end

  // system state register; reset settings are the power-on defaults
  always_ff @(posedge clk_sys or negedge rs2)
  begin
    if (!rs2)
      s <= '{t1: 1'b0, t2: 1'b0, t3: 1'b0, cfg: csc_pkg::CFG_RST};
    else
      s <= next_s;
  end

  // outputs straight from flops; the reference driver is fed from the
  // crystal buffer and only gated by pwr_ctl.ref_oe, no pll in its path
  assign serial_data_line_o = l.sda_o;
  assign serial_data_line_oe_n = l.sda_oe_n;
  assign synth_cfg = s.cfg;
endmodule

// ===== tb/csc_top_props.sv
`timescale 1ns/1ns
module csc_top_props #(
  parameter int XTAL_CYC = 20,
  parameter int PLL_CYC = 10
) (
  // clocks and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  // serial bus
  input wire logic serial_clock,
  input wire logic serial_data_line_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe_n,
  // device pins
  input wire logic output_enable_pin,
  input wire logic address_strap_pin,
  input wire logic supply_ok,
  input wire logic xtal_stable,
  // outputs under watch
  input wire csc_pkg::csc_cfg_t synth_cfg,
  input wire csc_pkg::csc_pwr_t pwr_ctl
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycles spent waiting on the crystal, then on the plls
  logic [15:0] xtal_cnt;
  logic [15:0] pll_cnt;
  // counters restart whenever their condition drops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtal_cnt <= 16'h0000;
      pll_cnt <= 16'h0000;
    end
    else
    begin
      xtal_cnt <= (pwr_ctl.xtal_en && supply_ok && xtal_stable && !pwr_ctl.pll100_en) ? xtal_cnt + 16'h0001 : 16'h0000;
      pll_cnt <= (pwr_ctl.pll100_en && !pwr_ctl.valid) ? pll_cnt + 16'h0001 : 16'h0000;
    end
  end
  // enable or supply held low long enough to pass the filter
  sequence s_off_held;
    !output_enable_pin [*8];
  endsequence
  sequence s_supply_lost;
    !supply_ok [*8];
  endsequence
  property p_off;
    s_off_held |-> pwr_ctl == '0;
  endproperty
  property p_no_supply;
    s_supply_lost |-> !pwr_ctl.pll100_en && !pwr_ctl.pllhs_en && !pwr_ctl.valid;
  endproperty
  a_off_disabled: assert property (p_off) else $error("outputs on while disabled");
  a_plls_need_supply: assert property (p_no_supply) else $error("plls on without supply");
  a_plls_need_xtal: assert property (pwr_ctl.pll100_en |-> pwr_ctl.xtal_en && pwr_ctl.pllhs_en == 1'b1)
    else $error("pll on without oscillator");
  a_outputs_together: assert property (pwr_ctl.valid == pwr_ctl.ref_oe && pwr_ctl.d100_oe == pwr_ctl.ref_oe
    && pwr_ctl.dhs_oe == pwr_ctl.ref_oe) else $error("outputs not switched together");
  a_xtal_wait: assert property ($rose(pwr_ctl.pll100_en) |-> xtal_cnt >= XTAL_CYC - 1 && xtal_cnt <= XTAL_CYC + 10)
    else $error("pll start off the crystal interval");
  a_pll_wait: assert property ($rose(pwr_ctl.valid) |-> pll_cnt >= PLL_CYC - 2 && pll_cnt <= PLL_CYC + 2)
    else $error("outputs valid off the pll interval");
  a_cfg_default: assert property (!$past(rst_n) |-> synth_cfg == csc_pkg::CFG_RST) else $error("bad default");
  a_cfg_at_idle: assert property ($changed(synth_cfg) |-> serial_clock && serial_data_line_i)
    else $error("settings changed inside a transfer");
  a_freq_range: assert property (synth_cfg.hs_freq <= csc_pkg::HS_FREQ_MAX) else $error("freq code out of range");
  a_data_open_drain: assert property ($fell(serial_data_line_oe_n) |-> !serial_clock && serial_data_line_o == 1'b0)
    else $error("acknowledge pulled outside clock low");
endmodule
bind csc_top csc_top_props #(.XTAL_CYC(XTAL_CYC), .PLL_CYC(PLL_CYC)) props (.clk_sys(clk_sys), .rst_n(rst_n),
  .clk_link(clk_link), .serial_clock(serial_clock), .serial_data_line_i(serial_data_line_i),
  .serial_data_line_o(serial_data_line_o), .serial_data_line_oe_n(serial_data_line_oe_n),
  .output_enable_pin(output_enable_pin), .address_strap_pin(address_strap_pin), .supply_ok(supply_ok),
  .xtal_stable(xtal_stable), .synth_cfg(synth_cfg), .pwr_ctl(pwr_ctl));

// ===== tb/csc_host_model.sv
`timescale 1ns/1ns
module csc_host_model #(
  parameter int Q = 50
) (
  // link clock and resolved data line
  input wire logic clk_link,
  input wire logic sda,
  // bus clock and data release (1 = let pull-up win)
  output logic scl,
  output logic sda_rel
);
  // bus idles high, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // a quarter bit of 50 link cycles keeps scl near 333 kHz
  task automatic wq();
    repeat (Q) @(posedge clk_link);
  endtask
  // one bit: data set while scl low, sampled mid high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_rel <= b;
    wq();
    scl <= 1'b1;
    wq();
    seen = sda;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  // start, n bytes msb first each with an ack slot, stop
  task automatic xfer(input logic [23:0] bytes, input int n, output logic [2:0] ack);
    logic s;
    int k;
    int i;
    ack = 3'h0;
    sda_rel <= 1'b0;
    wq();
    scl <= 1'b0;
    wq();
    for (k = 0; k < n; k++)
    begin
      for (i = 7; i >= 0; i--)
        put_bit(bytes[16 - 8 * k + i], s);
      put_bit(1'b1, s);
      ack[2 - k] = !s;
    end
    sda_rel <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_rel <= 1'b1;
    wq();
    wq();
  endtask
endmodule

// ===== tb/clock_synth_config_control_tb.sv
`timescale 1ns/1ns
module clock_synth_config_control_tb;
  // clocks, reset and device pins
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic en_pin = 1'b1;
  logic strap = 1'b1;
  logic supply = 1'b0;
  logic xtal = 1'b0;
  // bus lines, open drain with pull-up
  logic scl;
  logic sda_rel;
  logic sda_o;
  logic oe_n;
  wire sda = sda_rel & (oe_n | sda_o);
  // outputs, expectations and tallies
  csc_pkg::csc_cfg_t cfg;
  csc_pkg::csc_cfg_t exp = csc_pkg::CFG_RST;
  csc_pkg::csc_pwr_t pwr;
  logic [2:0] ack;
  logic [7:0] d;
  int failures = 0;
  int samples_checked = 0;
  int c;
  always #50 clk_sys = ~clk_sys;
  // 15 ns link clock, free of the system clock phase
  always
  begin
    #7 clk_link = ~clk_link;
    #8 clk_link = ~clk_link;
  end
  csc_top #(.XTAL_CYC(20), .PLL_CYC(10)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .serial_clock(scl), .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe_n(oe_n),
    .output_enable_pin(en_pin), .address_strap_pin(strap), .supply_ok(supply), .xtal_stable(xtal),
    .synth_cfg(cfg), .pwr_ctl(pwr));
  csc_host_model #(.Q(50)) host (.clk_link(clk_link), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one comparison
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask
  // bounded wait for the valid flag
  task automatic wait_valid();
    int n;
    n = 0;
    while (pwr.valid !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("valid", {7'h00, pwr.valid}, 8'h01);
    if (n == 200)
      finish_test();
  endtask
  // one bus write, then acks and the applied settings
  task automatic wr(input logic [23:0] b, input int n, input logic [2:0] want_ack);
    host.xfer(b, n, ack);
    repeat (20) @(posedge clk_sys);
    check("ack", {5'h00, ack}, {5'h00, want_ack});
    check("cfg", {1'b0, cfg}, {1'b0, exp});
  endtask
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    $display("[FAIL] run expected end seen timeout");
    finish_test();
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    check("cfg_rst", {1'b0, cfg}, {1'b0, exp});
    check("pwr_rst", {1'b0, pwr}, 8'h00);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check("pwr_wait", {1'b0, pwr}, 8'h40);
    supply <= 1'b1;
    xtal <= 1'b1;
    wait_valid();
    check("pwr_on", {1'b0, pwr}, 8'h7f);
    // every frequency code, both depths, spread on and off, then one code too high
    for (c = 0; c < 12; c++)
    begin
      d = {2'h0, c[0], c[1], c[3:0]};
      if (c <= 10)
      begin
        exp.hs_freq = c[3:0];
        exp.hs_ss_en = c[1];
        exp.hs_ss_depth = c[0];
      end
      wr({8'haa, 8'h01, d}, 3, (c <= 10) ? 3'h7 : 3'h6);
    end
    exp.ss100_en = 1'b0;
    wr({8'haa, 8'h00, 8'h00}, 3, 3'h7);
    exp.ss100_en = 1'b1;
    wr({8'haa, 8'h00, 8'h01}, 3, 3'h7);
    // index only, no data: nothing applied
    wr({8'haa, 8'h00, 8'h00}, 2, 3'h6);
    // address bit zero follows the strap
    wr({8'ha8, 8'h00, 8'h00}, 3, 3'h0);
    strap <= 1'b0;
    repeat (10) @(posedge clk_sys);
    exp.ss100_en = 1'b0;
    wr({8'ha8, 8'h00, 8'h00}, 3, 3'h7);
    // enable low: all off, settings still taken and kept
    en_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("pwr_dis", {1'b0, pwr}, 8'h00);
    exp.ss100_en = 1'b1;
    wr({8'ha8, 8'h00, 8'h01}, 3, 3'h7);
    check("pwr_dis2", {1'b0, pwr}, 8'h00);
    en_pin <= 1'b1;
    wait_valid();
    check("pwr_back", {1'b0, pwr}, 8'h7f);
    // supply lost: plls and outputs off, oscillator kept
    supply <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("pwr_sup", {1'b0, pwr}, 8'h40);
    supply <= 1'b1;
    wait_valid();
    check("cfg_end", {1'b0, cfg}, {1'b0, exp});
    finish_test();
  end
endmodule
